/* File: rtl/tcru_map.vh */
// tcru_map.vh - register offsets, control bit positions and timing counts for the
// third timer capture/reload unit. assumes 32-bit axi4-lite words.
`ifndef TCRU_MAP_VH
`define TCRU_MAP_VH

// byte offsets of the register words
`define TCRU_OFF_CTRL       8'h00
`define TCRU_OFF_COUNT      8'h04
`define TCRU_OFF_CAPT       8'h08
`define TCRU_OFF_IRQ_STAT   8'h0C
`define TCRU_OFF_IRQ_MASK   8'h10

// control register bit positions
`define TCRU_B_OVF          7
`define TCRU_B_EXT          6
`define TCRU_B_RXCLK        5
`define TCRU_B_TXCLK        4
`define TCRU_B_EXEN         3
`define TCRU_B_RUN          2
`define TCRU_B_CT           1
`define TCRU_B_CPRL         0

// reset values
`define TCRU_RST_CTRL       8'h00
`define TCRU_RST_WORD16     16'h0000
`define TCRU_RST_MASK       2'h0

// oscillator periods per machine cycle and per state time
`define TCRU_OSC_PER_MC     12
`define TCRU_OSC_PER_STATE  2

`endif

/* File: rtl/tcru_tick_gen.v */
// tcru_tick_gen.v - divides clk_sys into machine-cycle and state-time enable pulses.
// assumes clk_sys stands for the oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "tcru_map.vh"

module tcru_tick_gen #(
    parameter MC_DIV = `TCRU_OSC_PER_MC,
    parameter ST_DIV = `TCRU_OSC_PER_STATE
) (
    // clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // enables
    output reg  mc_tick,
    output reg  st_tick
);
    reg [3:0] mc_cnt_q;
    reg [3:0] st_cnt_q;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mc_cnt_q <= 4'h0;
            st_cnt_q <= 4'h0;
            mc_tick  <= 1'b0;
            st_tick  <= 1'b0;
        end else begin
            mc_tick <= (mc_cnt_q == MC_DIV[3:0] - 4'h1);
            st_tick <= (st_cnt_q == ST_DIV[3:0] - 4'h1);
            mc_cnt_q <= (mc_cnt_q == MC_DIV[3:0] - 4'h1) ? 4'h0 : mc_cnt_q + 4'h1;
            st_cnt_q <= (st_cnt_q == ST_DIV[3:0] - 4'h1) ? 4'h0 : st_cnt_q + 4'h1;
        end
    end
endmodule // tcru_tick_gen
`default_nettype wire

/* File: rtl/tcru_fall_det.v */
// tcru_fall_det.v - two-flop synchroniser plus falling-edge detector sampled on an enable.
// assumes pin_in is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module tcru_fall_det (
    // clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // sample enable and pin
    input  wire sample_en,
    input  wire pin_in,
    // one-cycle pulse when a high sample is followed by a low one
    output reg  fall_pulse
);
    reg meta_q;
    reg sync_q;
    reg samp_q;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q     <= 1'b1;
            sync_q     <= 1'b1;
            samp_q     <= 1'b1;
            fall_pulse <= 1'b0;
        end else begin
            meta_q     <= pin_in;
            sync_q     <= meta_q;
            fall_pulse <= 1'b0;
            if (sample_en) begin
                samp_q     <= sync_q;
                fall_pulse <= samp_q & ~sync_q;
            end
        end
    end
endmodule // tcru_fall_det
`default_nettype wire

/* File: rtl/tcru_top.v */
// tcru_top.v - third 16-bit timer/counter with capture, auto-reload and baud generator
// modes, reached over axi4-lite. assumes count_pin and trigger_pin are asynchronous.
// Notes on behaviour
// - overflow flag set on rollover, held till software clears, never in baud mode
// - external flag set when trigger edge captures or reloads with enable set
// - receive clock select routes our overflows to serial receive clock
// - transmit clock select routes our overflows to serial transmit clock
// - trigger edge acts only with enable set; enable clear ignores the pin
// - mode: off without run; baud if any clock select; else capture or reload
// - counter select 0 counts machine cycles (state times in baud mode), 1 counts count pin falls
// - capture on trigger edge; reload on overflow and on trigger edge
// - baud mode ignores capture select and reloads on overflow
// - capture mode without enable is a plain 16-bit counter
// - capture edge copies low and high count bytes to capture bytes
// - auto-reload rollover sets overflow flag and loads capture value
// - auto-reload trigger edge also reloads and sets external flag
// - timer_irq while overflow or external flag set, no mask; irq while a sticky status bit is set and enabled, and a status read clears it
// - baud mode internal counting advances every state time
// - baud mode trigger edge sets external flag with no reload
// - count pin sampled each machine cycle, high then low counts one
// - timer operation increments once per machine cycle outside baud mode
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcru_map.vh"

module tcru_top (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // pins
    input  wire        count_pin,
    input  wire        trigger_pin,
    // serial port clocking
    input  wire        other_timer_ovf,
    output reg         serial_rx_clk,
    output reg         serial_tx_clk,
    // interrupts
    output wire        timer_irq,
    output wire        irq
);
    // one-hot mode states
    localparam [3:0] MODE_OFF  = 4'b0001;
    localparam [3:0] MODE_RELD = 4'b0010;
    localparam [3:0] MODE_CAPT = 4'b0100;
    localparam [3:0] MODE_BAUD = 4'b1000;

    // axi response codes
    localparam [1:0] RESP_OKAY   = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    reg  [7:0]  ctrl_q;
    reg  [15:0] count_q;
    reg  [15:0] capt_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    reg  [3:0]  mode;

    wire mc_tick;
    wire st_tick;
    wire cnt_fall;
    wire trig_fall;

    // ------------- enables and pins
    tcru_tick_gen u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .mc_tick (mc_tick),
        .st_tick (st_tick)
    );

    // both pins sampled once per machine cycle
    tcru_fall_det u_cnt_pin (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .sample_en  (mc_tick),
        .pin_in     (count_pin),
        .fall_pulse (cnt_fall)
    );

    tcru_fall_det u_trig_pin (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .sample_en  (mc_tick),
        .pin_in     (trigger_pin),
        .fall_pulse (trig_fall)
    );

    wire run    = ctrl_q[`TCRU_B_RUN];
    wire exen   = ctrl_q[`TCRU_B_EXEN];
    wire rxsel  = ctrl_q[`TCRU_B_RXCLK];
    wire txsel  = ctrl_q[`TCRU_B_TXCLK];
    wire baudsel = rxsel | txsel;
    wire capt_sel = ctrl_q[`TCRU_B_CPRL];

    always @* begin
        if (!run)
            mode = MODE_OFF;
        else if (baudsel)
            mode = MODE_BAUD;
        else if (capt_sel)
            mode = MODE_CAPT;
        else
            mode = MODE_RELD;
    end

    // ------------- count enable
    reg inc_en;
    always @* begin
        // external edges still count in baud mode; state ticks feed only the internal source
        if (ctrl_q[`TCRU_B_CT])
            inc_en = cnt_fall;
        else if (mode == MODE_BAUD)
            inc_en = st_tick;
        else
            inc_en = mc_tick;
        if (mode == MODE_OFF)
            inc_en = 1'b0;
    end

    wire rollover = inc_en & (count_q == 16'hFFFF);
    // trigger is dead with enable clear; run does not gate it
    wire trig_hit = exen & trig_fall;

    // ------------- axi4-lite slave
    reg        aw_full_q;
    reg [7:0]  aw_addr_q;
    reg        w_full_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    // a held beat blocks its channel until its partner arrives, so writes never overlap
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_go = aw_full_q & w_full_q;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `TCRU_OFF_CTRL) || (a == `TCRU_OFF_COUNT) ||
                         (a == `TCRU_OFF_CAPT) || (a == `TCRU_OFF_IRQ_STAT) ||
                         (a == `TCRU_OFF_IRQ_MASK);
        end
    endfunction

    // registers sit on word boundaries; the byte bits of an address are dropped
    function [7:0] word_addr;
        input [7:0] a;
        begin
            word_addr = {a[7:2], 2'b00};
        end
    endfunction

    // byte-lane merge for the 16-bit count and capture fields
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    wire wr_ctrl  = wr_go & (aw_addr_q == `TCRU_OFF_CTRL) & w_strb_q[0];
    wire wr_count = wr_go & (aw_addr_q == `TCRU_OFF_COUNT);
    wire wr_capt  = wr_go & (aw_addr_q == `TCRU_OFF_CAPT);
    wire wr_mask  = wr_go & (aw_addr_q == `TCRU_OFF_IRQ_MASK) & w_strb_q[0];
    wire [7:0] ar_word = word_addr(s_axi_araddr);
    wire rd_stat  = rd_go & (ar_word == `TCRU_OFF_IRQ_STAT);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            aw_full_q    <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_full_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= word_addr(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_known(ar_word) ? RESP_OKAY : RESP_SLVERR;
            case (ar_word)
                `TCRU_OFF_CTRL:     s_axi_rdata <= {24'h000000, ctrl_q};
                `TCRU_OFF_COUNT:    s_axi_rdata <= {16'h0000, count_q};
                `TCRU_OFF_CAPT:     s_axi_rdata <= {16'h0000, capt_q};
                `TCRU_OFF_IRQ_STAT: s_axi_rdata <= {30'h00000000, irq_stat_q};
                `TCRU_OFF_IRQ_MASK: s_axi_rdata <= {30'h00000000, irq_mask_q};
                default:            s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------- control flags, counter, capture
    wire set_ovf = rollover & ~baudsel;
    wire set_ext = trig_hit;
    // this cycle's events, shared by the control flags and the sticky status
    wire [1:0] evt = {set_ext, set_ovf};

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q  <= `TCRU_RST_CTRL;
            count_q <= `TCRU_RST_WORD16;
            capt_q  <= `TCRU_RST_WORD16;
        end else begin
            if (wr_ctrl)
                ctrl_q <= w_data_q[7:0];
            // hardware set beats a software clear in the same cycle
            if (set_ovf)
                ctrl_q[`TCRU_B_OVF] <= 1'b1;
            if (set_ext)
                ctrl_q[`TCRU_B_EXT] <= 1'b1;

            if (wr_count)
                count_q <= merge16(count_q, w_data_q, w_strb_q);
            if (wr_capt)
                capt_q <= merge16(capt_q, w_data_q, w_strb_q);

            case (mode)
                MODE_CAPT: begin
                    if (inc_en)
                        count_q <= count_q + 16'h0001;
                    if (trig_hit) begin
                        capt_q[7:0]  <= count_q[7:0];
                        capt_q[15:8] <= count_q[15:8];
                    end
                end
                MODE_RELD: begin
                    if (rollover || trig_hit)
                        count_q <= capt_q;
                    else if (inc_en)
                        count_q <= count_q + 16'h0001;
                end
                MODE_BAUD: begin
                    if (rollover)
                        count_q <= capt_q;
                    else if (inc_en)
                        count_q <= count_q + 16'h0001; // trigger never reloads
                end
                MODE_OFF: begin
                    // clock selects leave the trigger a bare flag even while stopped
                    if (trig_hit && !baudsel) begin
                        if (capt_sel)
                            capt_q <= count_q;
                        else
                            count_q <= capt_q;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end

    // ------------- serial clock routing
    // both sources pass one flop, so neither is favoured in timing
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            serial_rx_clk <= 1'b0;
            serial_tx_clk <= 1'b0;
        end else begin
            serial_rx_clk <= rxsel ? rollover : other_timer_ovf;
            serial_tx_clk <= txsel ? rollover : other_timer_ovf;
        end
    end

    // ------------- interrupts
    assign timer_irq = ctrl_q[`TCRU_B_OVF] | ctrl_q[`TCRU_B_EXT];

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= `TCRU_RST_MASK;
        end else begin
            if (wr_mask)
                irq_mask_q <= w_data_q[1:0];
            // a read clears the status, but an event in that same cycle survives
            if (rd_stat)
                irq_stat_q <= evt;
            else
                irq_stat_q <= irq_stat_q | evt;
        end
    end

    // level follows only the sticky status, so a status read drops it
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule // tcru_top
`default_nettype wire

/* File: tb/tcru_assertions.sv */
// tcru_assertions.sv - port checks on tcru_top: bus handshake, reset, serial clock routing.
// assumes each write offers address and data together with wstrb[0] set.
`timescale 1ns/1ps
`default_nettype none

module tcru_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // serial clocking and interrupts
    input wire logic        other_timer_ovf,
    input wire logic        serial_rx_clk,
    input wire logic        serial_tx_clk,
    input wire logic        timer_irq,
    input wire logic        irq
);
    logic [1:0] sel_q;
    logic [1:0] sel_p_q;
    logic       take_q;
    wire        wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // shadow of the two clock selects; a write lands one edge after it is taken
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            take_q  <= 1'b0;
            sel_p_q <= 2'h0;
            sel_q   <= 2'h0;
        end else begin
            take_q  <= wr_take && s_axi_awaddr == 8'h00 && s_axi_wstrb[0];
            sel_p_q <= s_axi_wdata[5:4];
            if (take_q)
                sel_q <= sel_p_q;
        end
    end

    a_reset_quiet: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid
        && !timer_irq && !irq && !serial_rx_clk && !serial_tx_clk) else $error("not idle");
    a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    a_b_one_cycle: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_rx_route: assert property (!sel_q[1] |=> serial_rx_clk == $past(other_timer_ovf))
        else $error("receive clock not from other timer");
    a_tx_route: assert property (!sel_q[0] |=> serial_tx_clk == $past(other_timer_ovf))
        else $error("transmit clock not from other timer");
endmodule // tcru_checker

bind tcru_top tcru_checker i_tcru_checker (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .other_timer_ovf,
    .serial_rx_clk, .serial_tx_clk, .timer_irq, .irq);

`default_nettype wire

/* File: tb/tcru_pin_model.sv */
// tcru_pin_model.sv - external count and trigger pins, idle high, one fall per call.
// assumes clk_sys is the oscillator; levels are held at least one machine cycle.
`timescale 1ns/1ps
`default_nettype none

module tcru_pin_model (
    // clock
    input  wire logic clk_sys,
    // pins
    output var  logic count_pin,
    output var  logic trigger_pin
);
    initial begin
        count_pin = 1'b1;
        trigger_pin = 1'b1;
    end

    // high then low, each held at least a 12-clock sample period
    task automatic fall(input logic trig);
        repeat (12) @(posedge clk_sys);
        if (trig) trigger_pin <= 1'b0;
        else count_pin <= 1'b0;
        repeat (36) @(posedge clk_sys);
        if (trig) trigger_pin <= 1'b1;
        else count_pin <= 1'b1;
    endtask
endmodule // tcru_pin_model

`default_nettype wire

/* File: tb/tb.sv */
// tb.sv - register-level bench for tcru_top over axi4-lite.
// assumes tcru_pin_model drives the pins and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, other_timer_ovf = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    logic        count_pin, trigger_pin, serial_rx_clk, serial_tx_clk, timer_irq, irq;
    logic [2:0]  ovf_cnt = 3'h0;
    int          fails = 0, n_tests = 0, nrx, ntx;

    always #12.5 clk_sys = ~clk_sys;
    // stand-in for the other timer: one pulse in eight
    always @(posedge clk_sys) begin
        ovf_cnt <= ovf_cnt + 3'h1;
        other_timer_ovf <= (ovf_cnt == 3'h7);
    end

    tcru_top i_tcru_top (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_pin, .trigger_pin,
        .other_timer_ovf, .serial_rx_clk, .serial_tx_clk, .timer_irq, .irq);
    tcru_pin_model i_tcru_pin_model (.clk_sys, .count_pin, .trigger_pin);

    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cb(input logic g, e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    // ready/response lines are held high, so only valids move
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    task automatic wrs(input logic [15:0] cap, cnt, input logic [7:0] ctl);
        wr(8'h08, {16'h0, cap});
        wr(8'h04, {16'h0, cnt});
        wr(8'h00, {24'h0, ctl});
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a <= 16; a += 4) rc(a[7:0], 32'h0);
        rd(8'h14, d);
        chk({30'h0, rr}, 32'h2);
        chk(d, 32'h0);
        wr(8'h14, 32'h5);
        chk({30'h0, br}, 32'h2);
        wr(8'h00, 32'h04);
        repeat (240) @(posedge clk_sys);
        wr(8'h00, 32'h00);
        rd(8'h04, d);
        chk({31'h0, d >= 32'd20 && d <= 32'd21}, 32'h1);
        wr(8'h10, 32'h1);
        wrs(16'hFFF0, 16'hFFFD, 8'h04);
        repeat (40) @(posedge clk_sys);
        rc(8'h00, 32'h84);
        cb(timer_irq, 1'b1);
        cb(irq, 1'b1);
        rc(8'h0C, 32'h1);
        cb(irq, 1'b0);
        wr(8'h00, 32'h80);
        rd(8'h04, d);
        chk({31'h0, d >= 32'hFFF0 && d <= 32'hFFF2}, 32'h1);
        wr(8'h00, 32'h00);
        rc(8'h00, 32'h00);
        rc(8'h0C, 32'h0);
        cb(irq, 1'b0);
        // trigger edges: capture, ignored, reload, flag only
        wr(8'h10, 32'h0);
        wrs(16'h0000, 16'h1234, 8'h09);
        i_tcru_pin_model.fall(1'b1);
        rc(8'h08, 32'h1234);
        rc(8'h00, 32'h49);
        cb(timer_irq, 1'b1);
        cb(irq, 1'b0);
        rc(8'h0C, 32'h2);
        wrs(16'h0000, 16'h1234, 8'h01);
        i_tcru_pin_model.fall(1'b1);
        rc(8'h08, 32'h0);
        rc(8'h00, 32'h01);
        wrs(16'hABCD, 16'h0005, 8'h08);
        i_tcru_pin_model.fall(1'b1);
        rc(8'h04, 32'hABCD);
        rc(8'h00, 32'h48);
        wrs(16'hABCD, 16'h0005, 8'h38);
        i_tcru_pin_model.fall(1'b1);
        rc(8'h04, 32'h0005);
        rc(8'h00, 32'h78);
        // baud mode: reload every two state times
        wrs(16'hFFFE, 16'hFFFE, 8'h3C);
        nrx = 0;
        ntx = 0;
        repeat (80) begin
            @(posedge clk_sys);
            nrx += serial_rx_clk;
            ntx += serial_tx_clk;
        end
        chk({31'h0, nrx >= 19 && nrx <= 21}, 32'h1);
        chk({31'h0, ntx == nrx}, 32'h1);
        rc(8'h00, 32'h3C);
        wr(8'h00, 32'h30);
        rc(8'h00, 32'h30);
        wrs(16'h0000, 16'h0000, 8'h06);
        repeat (3) i_tcru_pin_model.fall(1'b0);
        rc(8'h04, 32'h3);
        wrs(16'h1111, 16'hFFFF, 8'h05);
        repeat (30) @(posedge clk_sys);
        rc(8'h00, 32'h85);
        wr(8'h00, 32'h80);
        rd(8'h04, d);
        chk({31'h0, d <= 32'h3}, 32'h1);
        rc(8'h00, 32'h80);
        final_report;
    end

    initial begin
        repeat (6000) @(posedge clk_sys);
        fails++;
        final_report;
    end
endmodule // tb

`default_nettype wire
